// ### hdl/rbtt_top.sv
// radio base timer targets: slot counter, target compares, snapshot, apb
// assumes apb master on ref_clk_in; wake-up inputs synchronous to it
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ns
`default_nettype none
module rbtt_top
   import rbtt_pkg::*;
#(
   parameter int unsigned SLOT_CYCLES_P = SLOT_CYCLES
)
(
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // apb slave
   input wire rbtt_apb_req_s apb_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // wake-up side
   input wire logic lp_wakeup_event_in,
   input wire logic radio_powered_in,
   input wire logic lp_clk_in,
   // block outputs
   output logic [PREFETCH_W-1:0] exchange_prefetch_time_out,
   output logic signal_strength_source_select_out,
   output logic coarse_target_irq_out,
   output logic slot_target_irq_out,
   output logic lp_wakeup_irq_out,
   output logic irq_out
);

   logic [PREFETCH_W-1:0] prefetch_q;
   logic [COARSE_W-1:0] coarse_target_q;
   logic [COUNT_W-1:0] slot_target_q;
   logic [COUNT_W-1:0] count_q;
   logic [COUNT_W-1:0] count_d;
   logic [COUNT_W-1:0] snapshot_q;
   logic [31:0] div_q;
   logic tick;
   logic capture_q;
   logic ss_select_q;
   logic wake_status_q;
   logic wake_ack;
   logic [IRQ_W-1:0] status_q;
   logic [IRQ_W-1:0] mask_q;
   logic [IRQ_W-1:0] events;
   logic coarse_hit;
   logic slot_hit;
   logic setup;
   logic wr_en;
   logic [31:0] rdata;
   logic known;

   function automatic logic hit(input logic [31:0] addr, input logic [31:0] offset);
      hit = (addr == offset);
   endfunction

   function automatic logic [31:0] zext_count(input logic [COUNT_W-1:0] v);
      zext_count = {{(32 - COUNT_W){1'b0}}, v};
   endfunction

   assign setup = apb_in.psel & ~apb_in.penable;
   assign wr_en = apb_in.psel & apb_in.penable & pready_out & apb_in.pwrite;

   // slot divider and base counter
   assign tick = (div_q == SLOT_CYCLES_P - 1);
   assign count_d = count_q + 27'h000_0001;

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         div_q <= 32'h0000_0000;
      end else if (tick) begin
         div_q <= 32'h0000_0000;
      end else begin
         div_q <= div_q + 32'h0000_0001;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         count_q <= COUNT_RESET;
      end else if (tick) begin
         count_q <= count_d;
      end
   end

   // compare only the new count value, so each match fires once per slot
   assign coarse_hit = tick && (count_d[COARSE_LO_W +: COARSE_W] == coarse_target_q)
                       && (count_d[COARSE_LO_W-1:0] == 4'h0);
   assign slot_hit = tick && (count_d == slot_target_q);

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         coarse_target_irq_out <= 1'b0;
         slot_target_irq_out <= 1'b0;
      end else begin
         coarse_target_irq_out <= coarse_hit;
         slot_target_irq_out <= slot_hit;
      end
   end

   // software-written configuration
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         prefetch_q <= PREFETCH_RESET;
         coarse_target_q <= COARSE_RESET;
         slot_target_q <= COUNT_RESET;
         ss_select_q <= 1'b0;
         mask_q <= IRQ_RESET;
      end else if (wr_en) begin
         if (hit(apb_in.paddr, EXCH_PREFETCH_CONTROL_OFFSET)) begin
            prefetch_q <= apb_in.pwdata[PREFETCH_W-1:0];
         end
         if (hit(apb_in.paddr, COARSE_TIMER_TARGET_OFFSET)) begin
            coarse_target_q <= apb_in.pwdata[COARSE_W-1:0];
         end
         if (hit(apb_in.paddr, SLOT_TIMER_TARGET_OFFSET)) begin
            slot_target_q <= apb_in.pwdata[COUNT_W-1:0];
         end
         if (hit(apb_in.paddr, RADIO_CONTROL_TWO_OFFSET)) begin
            ss_select_q <= apb_in.pwdata[SS_SELECT_BIT];
         end
         if (hit(apb_in.paddr, IRQ_MASK_OFFSET)) begin
            mask_q <= apb_in.pwdata[IRQ_W-1:0];
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         exchange_prefetch_time_out <= PREFETCH_RESET;
         signal_strength_source_select_out <= 1'b0;
      end else begin
         exchange_prefetch_time_out <= prefetch_q;
         signal_strength_source_select_out <= ss_select_q;
      end
   end

   // capture trigger: set by a one, snapshot next cycle, then self-clear
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         capture_q <= 1'b0;
         snapshot_q <= COUNT_RESET;
      end else if (capture_q) begin
         snapshot_q <= count_q;
         capture_q <= 1'b0;
      end else if (wr_en && hit(apb_in.paddr, TIME_COUNTER_SNAPSHOT_OFFSET)) begin
         capture_q <= apb_in.pwdata[CAPTURE_TRIGGER_BIT];
      end
   end

   // wake-up pending status; a new event beats a same-cycle acknowledge
   rbtt_wake_ack u_wake_ack (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .pending_in(wake_status_q),
      .radio_powered_in(radio_powered_in),
      .lp_clk_in(lp_clk_in),
      .ack_out(wake_ack)
   );

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wake_status_q <= 1'b0;
      end else if (lp_wakeup_event_in) begin
         wake_status_q <= 1'b1;
      end else if (wake_ack) begin
         wake_status_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         lp_wakeup_irq_out <= 1'b0;
      end else begin
         lp_wakeup_irq_out <= wake_status_q & ~wake_ack;
      end
   end

   // sticky status, write one to clear, set wins
   always_comb begin
      events = IRQ_RESET;
      events[IRQ_COARSE_BIT] = coarse_hit;
      events[IRQ_SLOT_BIT] = slot_hit;
      events[IRQ_CAPTURE_BIT] = capture_q;
      events[IRQ_WAKEUP_BIT] = lp_wakeup_event_in;
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         status_q <= IRQ_RESET;
      end else if (wr_en && hit(apb_in.paddr, IRQ_STATUS_OFFSET)) begin
         status_q <= (status_q & ~apb_in.pwdata[IRQ_W-1:0]) | events;
      end else begin
         status_q <= status_q | events;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |((status_q | events) & mask_q);
      end
   end

   // read mux
   always_comb begin
      rdata = RDATA_RESET;
      known = 1'b1;
      if (hit(apb_in.paddr, EXCH_PREFETCH_CONTROL_OFFSET)) begin
         rdata[PREFETCH_W-1:0] = prefetch_q;
      end else if (hit(apb_in.paddr, COARSE_TIMER_TARGET_OFFSET)) begin
         rdata[COARSE_W-1:0] = coarse_target_q;
      end else if (hit(apb_in.paddr, SLOT_TIMER_TARGET_OFFSET)) begin
         rdata = zext_count(slot_target_q);
      end else if (hit(apb_in.paddr, TIME_COUNTER_SNAPSHOT_OFFSET)) begin
         rdata[CAPTURE_TRIGGER_BIT] = capture_q;
      end else if (hit(apb_in.paddr, RADIO_CONTROL_TWO_OFFSET)) begin
         rdata[SS_SELECT_BIT] = ss_select_q;
         rdata[LP_WAKEUP_STATUS_BIT] = wake_status_q;
      end else if (hit(apb_in.paddr, IRQ_STATUS_OFFSET)) begin
         rdata[IRQ_W-1:0] = status_q;
      end else if (hit(apb_in.paddr, IRQ_MASK_OFFSET)) begin
         rdata[IRQ_W-1:0] = mask_q;
      end else if (hit(apb_in.paddr, BASE_TIME_COUNT_OFFSET)) begin
         rdata = zext_count(snapshot_q);
      end else begin
         known = 1'b0;
      end
   end

   // one fixed cycle: data captured at setup, ready in the first access cycle
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out <= RDATA_RESET;
      end else begin
         pready_out <= setup;
         pslverr_out <= setup & ~known;
         if (setup && !apb_in.pwrite) begin
            prdata_out <= rdata;
         end
      end
   end

endmodule
`default_nettype wire

// ### hdl/rbtt_pkg.sv
// constants, types and register map of the radio base timer target block
// assumes an apb master on a 32-bit bus and a 125 MHz reference clock
// How it works
// - eight-bit prefetch instant field, read/write, microseconds
// - coarse irq when target matches count 19:4, low nibble zero
// - slot irq when slot target equals whole count
// - writing capture trigger snapshots the base count
// - capture trigger clears itself after the snapshot
// - signal strength select: zero peak-hold, one average
// - read-only bit shows wake-up interrupt pending
// - wake-up acknowledged after power up plus lp period
package rbtt_pkg;

   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned SLOT_TIME_US = 625;
   localparam int unsigned SLOT_CYCLES = SLOT_TIME_US * 1000 / CLK_PERIOD_NS;

   localparam int unsigned COUNT_W = 27;
   localparam int unsigned COARSE_W = 16;
   localparam int unsigned PREFETCH_W = 8;

   localparam logic [31:0] EXCH_PREFETCH_CONTROL_OFFSET = 32'h4000_00f0;
   localparam logic [31:0] COARSE_TIMER_TARGET_OFFSET = 32'h4000_00f4;
   localparam logic [31:0] SLOT_TIMER_TARGET_OFFSET = 32'h4000_00f8;
   localparam logic [31:0] TIME_COUNTER_SNAPSHOT_OFFSET = 32'h4000_00fc;
   localparam logic [31:0] RADIO_CONTROL_TWO_OFFSET = 32'h4000_0200;
   localparam logic [31:0] IRQ_STATUS_OFFSET = 32'h4000_0210;
   localparam logic [31:0] IRQ_MASK_OFFSET = 32'h4000_0214;
   localparam logic [31:0] BASE_TIME_COUNT_OFFSET = 32'h4000_0218;

   // field positions
   localparam int unsigned CAPTURE_TRIGGER_BIT = 0;
   localparam int unsigned SS_SELECT_BIT = 21;
   localparam int unsigned LP_WAKEUP_STATUS_BIT = 20;
   localparam int unsigned COARSE_LO_W = 4;

   // irq status and mask layout
   localparam int unsigned IRQ_W = 4;
   localparam int unsigned IRQ_COARSE_BIT = 0;
   localparam int unsigned IRQ_SLOT_BIT = 1;
   localparam int unsigned IRQ_CAPTURE_BIT = 2;
   localparam int unsigned IRQ_WAKEUP_BIT = 3;

   // reset values
   localparam logic [PREFETCH_W-1:0] PREFETCH_RESET = 8'h00;
   localparam logic [COARSE_W-1:0] COARSE_RESET = 16'h0000;
   localparam logic [COUNT_W-1:0] COUNT_RESET = 27'h000_0000;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
   localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

   typedef struct packed {
      logic [31:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } rbtt_apb_req_s;

   typedef enum logic [1:0] {
      RBTT_ACK_IDLE = 2'b00,
      RBTT_ACK_POWER = 2'b01,
      RBTT_ACK_EDGE1 = 2'b10,
      RBTT_ACK_EDGE2 = 2'b11
   } rbtt_ack_state_e;

endpackage

// ### hdl/rbtt_wake_ack.sv
// wake-up acknowledge sequencer for the low-power wake-up interrupt
// assumes lp clock and power-good inputs synchronous to ref_clk_in
`timescale 1ns/1ns
`default_nettype none
module rbtt_wake_ack
   import rbtt_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // wake-up condition
   input wire logic pending_in,
   input wire logic radio_powered_in,
   input wire logic lp_clk_in,
   // acknowledge pulse
   output logic ack_out
);

   rbtt_ack_state_e state_q;
   logic lp_clk_q;
   logic lp_rise;

   assign lp_rise = lp_clk_in & ~lp_clk_q;

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         lp_clk_q <= 1'b0;
      end else begin
         lp_clk_q <= lp_clk_in;
      end
   end

   // a full lp period is counted rising edge to rising edge
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_q <= RBTT_ACK_IDLE;
         ack_out <= 1'b0;
      end else begin
         ack_out <= 1'b0;
         unique case (state_q)
            RBTT_ACK_IDLE: begin
               // pending still reads high in the ack cycle; do not re-arm on it
               if (pending_in && !ack_out) begin
                  state_q <= RBTT_ACK_POWER;
               end
            end
            RBTT_ACK_POWER: begin
               if (radio_powered_in) begin
                  state_q <= RBTT_ACK_EDGE1;
               end
            end
            RBTT_ACK_EDGE1: begin
               if (lp_rise) begin
                  state_q <= RBTT_ACK_EDGE2;
               end
            end
            RBTT_ACK_EDGE2: begin
               if (lp_rise) begin
                  state_q <= RBTT_ACK_IDLE;
                  ack_out <= 1'b1;
               end
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// ### verif/rbtt_assertions.sv
// port checks for rbtt_top
// assumes the apb map of rbtt_pkg and zero-wait answers
`timescale 1ns/1ns
`default_nettype none
module rbtt_assertions
   import rbtt_pkg::*;
#(
   parameter int unsigned SLOT_CYCLES_P = SLOT_CYCLES
)
(
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // apb
   input wire rbtt_apb_req_s apb_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   // wake-up and outputs
   input wire logic lp_wakeup_event_in,
   input wire logic radio_powered_in,
   input wire logic [PREFETCH_W-1:0] exchange_prefetch_time_out,
   input wire logic signal_strength_source_select_out,
   input wire logic coarse_target_irq_out,
   input wire logic slot_target_irq_out,
   input wire logic lp_wakeup_irq_out,
   input wire logic irq_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   logic setup_w, wdone_w, map_w;
   assign setup_w = apb_in.psel && !apb_in.penable;
   assign wdone_w = apb_in.psel && apb_in.penable && apb_in.pwrite && pready_out;
   assign map_w = apb_in.paddr inside {EXCH_PREFETCH_CONTROL_OFFSET, COARSE_TIMER_TARGET_OFFSET,
      SLOT_TIMER_TARGET_OFFSET, TIME_COUNTER_SNAPSHOT_OFFSET, RADIO_CONTROL_TWO_OFFSET,
      IRQ_STATUS_OFFSET, IRQ_MASK_OFFSET, BASE_TIME_COUNT_OFFSET};
   a_ready_after_setup: assert property (setup_w |=> pready_out) else $error("no pready");
   a_ready_one_cycle: assert property (pready_out |=> !pready_out) else $error("pready held");
   a_unmapped_error: assert property (setup_w && !map_w |=> pready_out && pslverr_out)
      else $error("no slave error");
   a_rdata_holds: assert property (!(setup_w && !apb_in.pwrite) |=> $stable(prdata_out))
      else $error("read data moved");
   a_prefetch_copy: assert property (wdone_w && apb_in.paddr == EXCH_PREFETCH_CONTROL_OFFSET
      |=> ##1 exchange_prefetch_time_out == $past(apb_in.pwdata[7:0], 2)) else $error("prefetch");
   a_select_copy: assert property (wdone_w && apb_in.paddr == RADIO_CONTROL_TWO_OFFSET
      |=> ##1 signal_strength_source_select_out == $past(apb_in.pwdata[21], 2))
      else $error("select");
   a_coarse_single: assert property (coarse_target_irq_out |=> !coarse_target_irq_out)
      else $error("coarse pulse long");
   a_slot_spacing: assert property (slot_target_irq_out |=> (!slot_target_irq_out)[*8])
      else $error("slot pulses too close");
   a_wake_sets: assert property (lp_wakeup_event_in |=> ##1 lp_wakeup_irq_out)
      else $error("wake not pending");
   a_wake_waits_power: assert property (lp_wakeup_irq_out && !radio_powered_in
      && !$past(radio_powered_in) |=> lp_wakeup_irq_out) else $error("early wake ack");
   c_slot: cover property (slot_target_irq_out && coarse_target_irq_out);
   c_wake_ack: cover property ($fell(lp_wakeup_irq_out));
   c_irq: cover property ($rose(irq_out));
endmodule
bind rbtt_top rbtt_assertions #(.SLOT_CYCLES_P(SLOT_CYCLES_P)) u_rbtt_chk (
   .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .apb_in(apb_in), .prdata_out(prdata_out),
   .pready_out(pready_out), .pslverr_out(pslverr_out), .lp_wakeup_event_in(lp_wakeup_event_in),
   .radio_powered_in(radio_powered_in), .exchange_prefetch_time_out(exchange_prefetch_time_out),
   .signal_strength_source_select_out(signal_strength_source_select_out),
   .coarse_target_irq_out(coarse_target_irq_out), .slot_target_irq_out(slot_target_irq_out),
   .lp_wakeup_irq_out(lp_wakeup_irq_out), .irq_out(irq_out));
`default_nettype wire

// ### verif/rbtt_top_tb.sv
// bench for rbtt_top: registers, targets, capture, interrupts, wake-up
// assumes zero-wait apb answers and a 20-cycle slot
`timescale 1ns/1ns
`default_nettype none
module rbtt_top_tb
   import rbtt_pkg::*;
;
   logic ref_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic wake_ev = 1'b0;
   logic powered = 1'b0;
   logic lp_clk = 1'b0;
   rbtt_apb_req_s req = '0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, ss_sel, c_irq, s_irq, w_irq, irq, c;
   logic [7:0] pf;
   int errors = 0, cmp_count = 0, cyc = 0, c_n = 0, lp_n = 0;
   logic [31:0] ra [8] = '{EXCH_PREFETCH_CONTROL_OFFSET, COARSE_TIMER_TARGET_OFFSET,
      SLOT_TIMER_TARGET_OFFSET, TIME_COUNTER_SNAPSHOT_OFFSET, RADIO_CONTROL_TWO_OFFSET,
      IRQ_STATUS_OFFSET, IRQ_MASK_OFFSET, BASE_TIME_COUNT_OFFSET};
   rbtt_top #(.SLOT_CYCLES_P(20)) DUT (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
      .apb_in(req), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .lp_wakeup_event_in(wake_ev), .radio_powered_in(powered), .lp_clk_in(lp_clk),
      .exchange_prefetch_time_out(pf), .signal_strength_source_select_out(ss_sel),
      .coarse_target_irq_out(c_irq), .slot_target_irq_out(s_irq),
      .lp_wakeup_irq_out(w_irq), .irq_out(irq));
   always #4 ref_clk_in = ~ref_clk_in;
   // slow lp clock keeps running; edges counted only once powered
   always @(posedge ref_clk_in) begin
      cyc++;
      if (c_irq === 1'b1) c_n++;
      if (cyc % 8 == 0) lp_clk <= ~lp_clk;
      if (cyc % 8 == 0 && !lp_clk && powered) lp_n++;
      if (cyc == 20000) begin
         errors++;
         complete_run();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // no wait limit here: only the cycle ceiling ends a hung transfer
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge ref_clk_in);
      req <= '{a, 1'b1, 1'b0, w, d};
      @(posedge ref_clk_in);
      req.penable <= 1'b1;
      do begin
         @(posedge ref_clk_in);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
      chk("slave error", 32'h0, 32'(err));
   endtask
   task automatic wait_slot();
      do begin
         @(posedge ref_clk_in);
      end while (s_irq !== 1'b1);
      c = c_irq;
   endtask
   task automatic complete_run();
      $display("errors %0d comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      foreach (ra[i]) rdc("reset value", ra[i], 32'h0);
      apb(1'b1, ra[0], 32'hffff_ffa5);
      rdc("prefetch", ra[0], 32'ha5);
      chk("prefetch pin", 32'ha5, 32'(pf));
      apb(1'b1, ra[4], 32'hffff_ffff);
      rdc("control two", ra[4], 32'h20_0000);
      chk("select pin", 32'h1, 32'(ss_sel));
      apb(1'b1, ra[4], 32'h0);
      rdc("control two", ra[4], 32'h0);
      chk("select pin", 32'h0, 32'(ss_sel));
      apb(1'b1, ra[1], 32'hffff_0001);
      rdc("coarse target", ra[1], 32'h1);
      apb(1'b1, ra[2], 32'hf800_0010);
      rdc("slot target", ra[2], 32'h10);
      apb(1'b0, 32'h4000_0204, 32'h0);
      chk("unmapped error", 32'h1, 32'(err));
      chk("unmapped data", 32'h0, rd);
      // count 16 has a zero low nibble, so both targets fire together
      wait_slot();
      chk("coarse with slot", 32'h1, 32'(c));
      apb(1'b1, ra[3], 32'h1);
      rdc("trigger", ra[3], 32'h0);
      rdc("snapshot", ra[7], 32'h10);
      c_n = 0;
      apb(1'b1, ra[1], 32'h2);
      apb(1'b1, ra[2], 32'h28);
      wait_slot();
      chk("coarse count", 32'h1, 32'(c_n));
      chk("coarse off nibble", 32'h0, 32'(c));
      apb(1'b1, ra[3], 32'h1);
      rdc("snapshot", ra[7], 32'h28);
      rdc("status", ra[5], 32'h7);
      chk("irq masked", 32'h0, 32'(irq));
      apb(1'b1, ra[6], 32'h2);
      repeat (3) @(posedge ref_clk_in);
      chk("irq unmasked", 32'h1, 32'(irq));
      apb(1'b1, ra[5], 32'h2);
      repeat (3) @(posedge ref_clk_in);
      chk("irq cleared", 32'h0, 32'(irq));
      rdc("status", ra[5], 32'h5);
      apb(1'b1, ra[5], 32'hf);
      apb(1'b1, ra[6], 32'h8);
      wake_ev <= 1'b1;
      @(posedge ref_clk_in);
      wake_ev <= 1'b0;
      rdc("wake status", ra[4], 32'h10_0000);
      repeat (40) @(posedge ref_clk_in);
      chk("wake held", 32'h1, 32'(w_irq));
      chk("wake irq", 32'h1, 32'(irq));
      powered <= 1'b1;
      lp_n = 0;
      do apb(1'b0, ra[4], 32'h0); while (rd[20] !== 1'b0);
      chk("lp edges", 32'h1, 32'(lp_n >= 2));
      chk("wake irq off", 32'h0, 32'(w_irq));
      apb(1'b1, ra[5], 32'hf);
      rdc("status", ra[5], 32'h0);
      complete_run();
   end
endmodule
`default_nettype wire
